// ===== hdl/pdma_regs.sv
// Register logic of the parallel DMA interface: count, pointer, control and
// data buffers, plus the user port. Reset stands for bus initialization.
`timescale 1ns/1ps
module pdma_regs #(
  parameter int ADDR_W = 18,
  parameter int TIMEOUT_CYC = pdma_pkg::REPLY_TIMEOUT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic regByte,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  output logic regAck,
  output logic intRequest,
  output logic memReq,
  output logic memWrite,
  output logic memByte,
  output logic [ADDR_W-1:0] memAddr,
  output logic [15:0] memWdata,
  input wire logic memReply,
  input wire logic [15:0] memRdata,
  input wire logic [15:0] userDataIn,
  input wire logic userInLoad,
  input wire logic userAddr0,
  input wire logic userAttention,
  input wire logic [2:0] userStatus,
  input wire logic userCycleReq,
  input wire logic userC1,
  input wire logic userC0,
  input wire logic ptrIncEnable,
  input wire logic countIncEnable,
  output logic [15:0] userDataOut,
  output logic [2:0] userFunction,
  output logic userReady,
  output logic userBusy_n,
  output logic userInit
);
  if (ADDR_W != 16 && ADDR_W != 18)
  begin : g_chk
    $error("ADDR_W must be 16 or 18");
  end

  logic [15:0] count_ff;
  logic [15:1] pointer_ff;
  logic [1:0] xad_ff;
  logic [2:0] func_ff;
  logic ie_ff;
  logic ready_ff;
  logic cycle_ff;
  logic diagnostic_loop_bit_ff;
  logic nex_ff;
  logic dmaEn_ff;
  logic errPrev_ff;
  logic [15:0] inHold_ff;
  logic [15:0] outHold_ff;
  logic [15:0] control;
  logic errorNow;
  logic errRise;
  logic wrCount;
  logic wrPointer;
  logic wrControl;
  logic wrBuffer;
  logic wrLow;
  logic wrHigh;
  logic goCmd;
  logic start;
  logic seqBusy;
  logic seqDone;
  logic seqFail;
  logic [15:0] seqRdata;
  logic toMemory;
  logic countEnd;
  logic [16:0] nxt_wordPtr;
  logic [15:0] nxt_count;
  logic [ADDR_W-1:0] xferAddr;
  pdma_pkg::pdma_acc_t acc;

  // Decodes the processor access width from the byte flag and address bit 0
  function automatic pdma_pkg::pdma_acc_t accKind(input logic isByte, input logic odd);
    if (!isByte)
      return pdma_pkg::ACC_WORD;
    else if (odd)
      return pdma_pkg::ACC_HIGH;
    else
      return pdma_pkg::ACC_LOW;
  endfunction

  // Merges written bytes into a held word according to the access width
  function automatic logic [15:0] mergeBytes(
    input logic [15:0] old,
    input logic [15:0] data,
    input pdma_pkg::pdma_acc_t kind
  );
    case (kind)
      pdma_pkg::ACC_LOW: return {old[15:8], data[7:0]};
      pdma_pkg::ACC_HIGH: return {data[15:8], old[7:0]};
      default: return data;
    endcase
  endfunction

  assign acc = accKind(regByte, regAddr[0]);
  assign wrLow = regWrite && acc != pdma_pkg::ACC_HIGH;
  assign wrHigh = regWrite && acc != pdma_pkg::ACC_LOW;
  // Byte writes to the counting registers are dropped, not widened
  assign wrCount = regWrite && acc == pdma_pkg::ACC_WORD
    && {regAddr[2:1], 1'b0} == pdma_pkg::OFS_COUNT;
  assign wrPointer = regWrite && acc == pdma_pkg::ACC_WORD
    && {regAddr[2:1], 1'b0} == pdma_pkg::OFS_POINTER;
  assign wrControl = regWrite && {regAddr[2:1], 1'b0} == pdma_pkg::OFS_CONTROL;
  assign wrBuffer = regWrite && {regAddr[2:1], 1'b0} == pdma_pkg::OFS_BUFFER;
  assign goCmd = wrControl && wrLow && regWdata[pdma_pkg::BIT_GO];

  assign errorNow = nex_ff || userAttention;
  assign errRise = errorNow && !errPrev_ff;
  assign toMemory = userC1;
  assign nxt_wordPtr = {xad_ff, pointer_ff} + 17'h00001;
  assign nxt_count = count_ff + 16'h0001;
  assign countEnd = seqDone && countIncEnable && nxt_count == 16'h0000;
  // A narrow bus simply drops the extended bits, so the address wraps to zero
  assign xferAddr = ADDR_W'({xad_ff, pointer_ff, userAddr0});
  // No new cycle while an error stands; only a later go reopens the path
  assign start = cycle_ff && dmaEn_ff && !errorNow && !seqBusy;

  always_comb
  begin
    control = 16'h0000;
    control[pdma_pkg::BIT_ERROR] = errorNow;
    control[pdma_pkg::BIT_NEX] = nex_ff;
    control[pdma_pkg::BIT_USER_ATTENTION] = userAttention;
    control[pdma_pkg::BIT_DIAGNOSTIC_LOOP_BIT] = diagnostic_loop_bit_ff;
    control[pdma_pkg::BIT_STAT_LO +: 3] = userStatus;
    control[pdma_pkg::BIT_CYCLE] = cycle_ff;
    control[pdma_pkg::BIT_READY] = ready_ff;
    control[pdma_pkg::BIT_IE] = ie_ff;
    control[pdma_pkg::BIT_XAD17:pdma_pkg::BIT_XAD16] = xad_ff;
    control[pdma_pkg::BIT_FUNC_LO +: 3] = func_ff;
    control[pdma_pkg::BIT_GO] = 1'b0;
  end

  pdma_cycle #(
    .ADDR_W(ADDR_W),
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_cycle (
    .clock(clock),
    .rst_n(rst_n),
    .start(start),
    .toMemory(toMemory),
    .byteMode(userC1 && userC0),
    .addr(xferAddr),
    .wdata(inHold_ff),
    .memReq(memReq),
    .memWrite(memWrite),
    .memByte(memByte),
    .memAddr(memAddr),
    .memWdata(memWdata),
    .memReply(memReply),
    .memRdata(memRdata),
    .busy(seqBusy),
    .done(seqDone),
    .fail(seqFail),
    .rdata(seqRdata)
  );

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      count_ff <= pdma_pkg::RST_WORD;
    else if (wrCount)
      count_ff <= regWdata;
    else if (seqDone && countIncEnable)
      count_ff <= nxt_count;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pointer_ff <= pdma_pkg::RST_WORD[15:1];
      xad_ff <= pdma_pkg::RST_XAD;
    end
    else
    begin
      if (wrPointer)
        pointer_ff <= regWdata[15:1];
      else if (seqDone && ptrIncEnable)
        pointer_ff <= nxt_wordPtr[14:0];
      if (wrControl && wrLow)
        xad_ff <= regWdata[pdma_pkg::BIT_XAD17:pdma_pkg::BIT_XAD16];
      else if (seqDone && ptrIncEnable)
        xad_ff <= nxt_wordPtr[16:15];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      func_ff <= pdma_pkg::RST_FUNC;
      ie_ff <= pdma_pkg::RST_IE;
    end
    else if (wrControl && wrLow)
    begin
      func_ff <= regWdata[pdma_pkg::BIT_FUNC_LO +: 3];
      ie_ff <= regWdata[pdma_pkg::BIT_IE];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      diagnostic_loop_bit_ff <= 1'b0;
    else if (wrControl && wrHigh)
      diagnostic_loop_bit_ff <= regWdata[pdma_pkg::BIT_DIAGNOSTIC_LOOP_BIT];
  end

  // A user request in the very cycle a transfer starts stays pending
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      cycle_ff <= 1'b0;
    else if (userCycleReq)
      cycle_ff <= 1'b1;
    else if (start)
      cycle_ff <= 1'b0;
    else if (wrControl && wrHigh)
      cycle_ff <= regWdata[pdma_pkg::BIT_CYCLE];
  end

  // Software may only clear the flag; a failing cycle in the same edge wins
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      nex_ff <= 1'b0;
    else if (seqFail)
      nex_ff <= 1'b1;
    else if (wrControl && wrHigh && !regWdata[pdma_pkg::BIT_NEX])
      nex_ff <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      errPrev_ff <= 1'b0;
    else
      errPrev_ff <= errorNow;
  end

  // Setting events beat a go in the same edge so no completion is lost
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      ready_ff <= pdma_pkg::RST_READY;
    else if (errRise || countEnd)
      ready_ff <= 1'b1;
    else if (goCmd)
      ready_ff <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      dmaEn_ff <= 1'b0;
    else if (errRise || countEnd)
      dmaEn_ff <= 1'b0;
    else if (goCmd)
      dmaEn_ff <= 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      inHold_ff <= pdma_pkg::RST_WORD;
    else if (userInLoad)
      inHold_ff <= userDataIn;
  end

  // A DMA read from memory takes priority over a processor write
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      outHold_ff <= pdma_pkg::RST_WORD;
    // Latched direction, so a late change on the user's direction pin cannot misroute data
    else if (seqDone && !memWrite)
      outHold_ff <= seqRdata;
    else if (wrBuffer)
      outHold_ff <= mergeBytes(outHold_ff, regWdata, acc);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      regRdata <= 16'h0000;
      regAck <= 1'b0;
    end
    else
    begin
      regAck <= regRead || regWrite;
      if (regRead)
        case ({regAddr[2:1], 1'b0})
          pdma_pkg::OFS_COUNT: regRdata <= count_ff;
          pdma_pkg::OFS_POINTER: regRdata <= {pointer_ff, userAddr0};
          pdma_pkg::OFS_CONTROL: regRdata <= control;
          pdma_pkg::OFS_BUFFER: regRdata <= inHold_ff;
          default: regRdata <= 16'h0000;
        endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      userInit <= 1'b1;
      intRequest <= 1'b0;
      userReady <= pdma_pkg::RST_READY;
      userBusy_n <= 1'b1;
    end
    else
    begin
      userInit <= 1'b0;
      intRequest <= ready_ff && ie_ff;
      userReady <= ready_ff;
      userBusy_n <= !seqBusy;
    end
  end

  assign userDataOut = outHold_ff;
  assign userFunction = func_ff;
endmodule

// ===== shared/pdma_pkg.sv
// Constants shared by the parallel DMA register logic and its bus cycle unit.
// Assumes a 40 MHz clock and a processor port addressed by byte offset.
//
// Contract
// - Pointer is 16 bits, upper fifteen software writable
// - Pointer bit zero comes from user device
// - Pointer increments, carrying into extended bits
// - Sixteen address lines wrap to location zero
// - Pointer accepts full word accesses only
// - Control register allows word and byte access
// - Only bits 0-6, 8, 12 writable; 14 zero
// - Go bit acts on write, reads zero
// - Bit 15 is missing-reply or attention
// - Error rising sets ready, may interrupt
// - Bit 14 cleared by reset or zero write
// - Bit 13 mirrors user attention input
// - Bit 12 is diagnostic read/write bit
// - Bits 11-9 show user status inputs
// - Bit 8 primes next DMA bus cycle
// - Ready set by reset, may interrupt
// - Interrupt enable gates ready, reset clears it
// - Bits 5-4 are address bits 17-16
// - Bits 3-1 drive user function outputs
// - User loads input buffer; DMA or processor reads
// - Input and output buffers share one address
// - Output buffer loaded by DMA or processor writes
// - Count register increments; zero ends, sets ready
package pdma_pkg;
  localparam logic [2:0] OFS_COUNT = 3'h0;
  localparam logic [2:0] OFS_POINTER = 3'h2;
  localparam logic [2:0] OFS_CONTROL = 3'h4;
  localparam logic [2:0] OFS_BUFFER = 3'h6;

  localparam int BIT_GO = 0;
  localparam int BIT_FUNC_LO = 1;
  localparam int BIT_XAD16 = 4;
  localparam int BIT_XAD17 = 5;
  localparam int BIT_IE = 6;
  localparam int BIT_READY = 7;
  localparam int BIT_CYCLE = 8;
  localparam int BIT_STAT_LO = 9;
  localparam int BIT_DIAGNOSTIC_LOOP_BIT = 12;
  localparam int BIT_USER_ATTENTION = 13;
  localparam int BIT_NEX = 14;
  localparam int BIT_ERROR = 15;

  localparam logic RST_READY = 1'b1;
  localparam logic RST_IE = 1'b0;
  localparam logic [1:0] RST_XAD = 2'h0;
  localparam logic [2:0] RST_FUNC = 3'h0;
  localparam logic [15:0] RST_WORD = 16'h0000;

  localparam int CLK_PERIOD_PS = 25000;
  localparam int REPLY_WAIT_NS = 10000;
  localparam int REPLY_TIMEOUT_CYC = (REPLY_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    ACC_WORD,
    ACC_LOW,
    ACC_HIGH
  } pdma_acc_t;
endpackage

// ===== hdl/pdma_cycle.sv
// Bus master cycle unit: runs one memory cycle and watches for the reply.
// Assumes memory answers with a one-cycle memReply pulse while memReq stands.
`timescale 1ns/1ps
module pdma_cycle #(
  parameter int ADDR_W = 18,
  parameter int TIMEOUT_CYC = pdma_pkg::REPLY_TIMEOUT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic toMemory,
  input wire logic byteMode,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  output logic memReq,
  output logic memWrite,
  output logic memByte,
  output logic [ADDR_W-1:0] memAddr,
  output logic [15:0] memWdata,
  input wire logic memReply,
  input wire logic [15:0] memRdata,
  output logic busy,
  output logic done,
  output logic fail,
  output logic [15:0] rdata
);
  typedef enum logic {IDLE, WAIT} pdma_cyc_t;

  if (TIMEOUT_CYC < 2 || TIMEOUT_CYC > 65535)
  begin : g_chk
    $error("TIMEOUT_CYC out of range");
  end

  pdma_cyc_t state_ff;
  logic [15:0] waitCnt_ff;
  logic timeUp;

  assign timeUp = (waitCnt_ff == 16'(TIMEOUT_CYC - 1));
  assign memReq = (state_ff == WAIT);
  assign busy = (state_ff == WAIT);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      state_ff <= IDLE;
    else
      case (state_ff)
        IDLE: if (start) state_ff <= WAIT;
        WAIT: if (memReply || timeUp) state_ff <= IDLE;
        default: state_ff <= IDLE;
      endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n || state_ff != WAIT)
      waitCnt_ff <= 16'h0000;
    else
      waitCnt_ff <= waitCnt_ff + 16'h0001;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      memWrite <= 1'b0;
      memByte <= 1'b0;
      memAddr <= '0;
      memWdata <= 16'h0000;
    end
    else if (start && state_ff == IDLE)
    begin
      memWrite <= toMemory;
      memByte <= byteMode;
      memAddr <= addr;
      memWdata <= wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      done <= 1'b0;
      fail <= 1'b0;
      rdata <= 16'h0000;
    end
    else
    begin
      done <= (state_ff == WAIT) && memReply;
      // No reply within the timeout ends the cycle here as a failure
      fail <= (state_ff == WAIT) && !memReply && timeUp;
      if (state_ff == WAIT && memReply)
        rdata <= memRdata;
    end
  end
endmodule

// ===== tb/pdma_regs_monitor.sv
// Concurrent checks on the register port, memory request and user outputs.
// Assumes it is bound to the register logic and sees only its ports.
`timescale 1ns/1ps
module pdma_regs_monitor #(
  parameter int TIMEOUT_CYC = pdma_pkg::REPLY_TIMEOUT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic regByte,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic regAck,
  input wire logic intRequest,
  input wire logic memReq,
  input wire logic userAttention,
  input wire logic [2:0] userStatus,
  input wire logic [15:0] userDataOut,
  input wire logic [2:0] userFunction,
  input wire logic userReady,
  input wire logic userInit
);
  logic [15:0] waitCnt_ff;
  logic [15:0] lastWdata_ff;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // A counter holds the reply wait, so the bound follows the parameter
  always_ff @(posedge clock)
  begin
    waitCnt_ff <= (!rst_n || !memReq) ? 16'h0000 : waitCnt_ff + 16'h0001;
  end
  always_ff @(posedge clock)
  begin
    lastWdata_ff <= regWdata;
  end
  sequence ctlRead;
    regRead && regAddr[2:1] == 2'h2;
  endsequence
  sequence ctlLowWrite;
    regWrite && regAddr == 3'h4;
  endsequence
  sequence ieSetNoGo;
    ctlLowWrite ##0 regWdata[6] && !regWdata[0];
  endsequence
  chk_bus_ack: assert property ((regWrite || regRead) |=> regAck)
    else $error("register access not acknowledged");
  chk_go_reads_zero: assert property (ctlRead |=> !regRdata[0])
    else $error("go bit read back as one");
  chk_user_attention_error: assert property (
    userAttention [*2] ##0 ctlRead |=> regRdata[13] && regRdata[15])
    else $error("attention not shown in status");
  chk_status_mirror: assert property (
    ctlRead ##0 $stable(userStatus) |=> regRdata[11:9] == $past(userStatus))
    else $error("status inputs not shown");
  chk_func_out: assert property (ctlLowWrite |=> userFunction == lastWdata_ff[3:1])
    else $error("function outputs differ from written bits");
  chk_buf_load: assert property (
    regWrite && regAddr == 3'h6 && !regByte |=> userDataOut == lastWdata_ff)
    else $error("output buffer not loaded by word write");
  chk_reply_bound: assert property (waitCnt_ff <= TIMEOUT_CYC + 2)
    else $error("memory request outlived the reply timeout");
  chk_int_ready: assert property (intRequest |-> userReady)
    else $error("interrupt without ready");
  chk_ie_raises_int: assert property (
    ieSetNoGo ##1 userReady |=> intRequest)
    else $error("enabled ready raised no interrupt");
  chk_go_notready: assert property (
    ctlLowWrite ##0 regWdata[0] && !userAttention && !memReq |=> ##1 !userReady)
    else $error("go did not drop ready");
  chk_reset_init: assert property (
    disable iff (1'b0) !rst_n |=> userInit && userReady && !intRequest && userFunction == 3'h0)
    else $error("reset values wrong");
endmodule

// ===== tb/pdma_mem_model.sv
// Behavioural memory on the DMA bus side, answering each request after a set delay.
// Assumes requests stand until answered; mute withholds the reply entirely.
`timescale 1ns/1ps
module pdma_mem_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [17:0] memAddr,
  input wire logic [15:0] memWdata,
  input wire logic [3:0] delay,
  input wire logic mute,
  output logic memReply,
  output logic [15:0] memRdata,
  output logic [15:0] lastWrite
);
  logic [3:0] cnt_ff;
  always_ff @(posedge clock)
  begin
    if (!rst_n || !memReq || memReply || mute || cnt_ff != delay)
    begin
      cnt_ff <= (!rst_n || !memReq || memReply) ? 4'h0 : cnt_ff + 4'h1;
      memReply <= 1'b0;
      // Read data is not held outside a reply, so stale values never pass
      memRdata <= rst_n ? ~memRdata : 16'h0000;
    end
    else
    begin
      memReply <= 1'b1;
      memRdata <= {memAddr[7:0], 8'hC3};
      if (memWrite)
        lastWrite <= memWdata;
    end
  end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the DMA register logic; the bench plays the user device.
// Assumes the behavioural memory on the bus side and a shortened reply timeout.
`timescale 1ns/1ps
module tb;
  localparam int TO = 8;
  typedef struct {logic [2:0] a; logic b; logic [15:0] d; logic [2:0] ra; logic [15:0] e;} pdma_row_t;
  logic clock = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, regByte = 1'b0;
  logic userInLoad = 1'b0, userAddr0 = 1'b0, userAttention = 1'b0, userCycleReq = 1'b0;
  logic userC1 = 1'b0, userC0 = 1'b0, ptrIncEnable = 1'b1, countIncEnable = 1'b1, mute = 1'b0;
  logic [2:0] regAddr = 3'h0, userStatus = 3'h5, userFunction;
  logic [15:0] regWdata = 16'h0000, userDataIn = 16'h5A3C, regRdata, memWdata, memRdata;
  logic [15:0] userDataOut, lastWrite, rv, exp;
  logic [17:0] memAddr;
  logic [3:0] delay = 4'h1;
  logic [1:0] x = 2'h0;
  logic regAck, intRequest, memReq, memWrite, memByte, memReply, userReady, userBusy_n, userInit;
  int errors = 0, checked = 0;
  pdma_row_t rows [8] = '{'{3'h4, 1'b0, 16'h007E, 3'h4, 16'h0AFE},
    '{3'h4, 1'b0, 16'hFFFE, 3'h4, 16'h1BFE}, '{3'h4, 1'b1, 16'h0000, 3'h4, 16'h1B80},
    '{3'h5, 1'b1, 16'h0000, 3'h4, 16'h0A80}, '{3'h2, 1'b0, 16'h1235, 3'h2, 16'h1234},
    '{3'h2, 1'b1, 16'h00FF, 3'h2, 16'h1234}, '{3'h6, 1'b0, 16'hBEEF, 3'h6, 16'h5A3C},
    '{3'h0, 1'b0, 16'h8001, 3'h0, 16'h8001}};
  pdma_regs #(.ADDR_W(18), .TIMEOUT_CYC(TO)) i_pdma_regs (.clock, .rst_n, .regAddr, .regWrite,
    .regRead, .regByte, .regWdata, .regRdata, .regAck, .intRequest, .memReq, .memWrite,
    .memByte, .memAddr, .memWdata, .memReply, .memRdata, .userDataIn, .userInLoad, .userAddr0,
    .userAttention, .userStatus, .userCycleReq, .userC1, .userC0, .ptrIncEnable,
    .countIncEnable, .userDataOut, .userFunction, .userReady, .userBusy_n, .userInit);
  pdma_mem_model i_pdma_mem_model (.clock, .rst_n, .memReq, .memWrite, .memAddr, .memWdata,
    .delay, .mute, .memReply, .memRdata, .lastWrite);
  always #12.5 clock = ~clock;
  task automatic stop_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [17:0] e, input logic [17:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clock);
      #2;
    end
  endtask
  // Two cycles per access keep every strobe edge in its own time step
  task automatic bus(input logic w, input logic [2:0] a, input logic b, input logic [15:0] d);
    {regWrite, regRead, regAddr, regByte, regWdata} = {w, ~w, a, b, d};
    tick(1);
    rv = regRdata;
    {regWrite, regRead} = 2'b00;
    tick(1);
  endtask
  task automatic await(input logic sel, input logic v);
    int n;
    n = 0;
    while ((sel ? userReady : memReq) !== v)
    begin
      tick(1);
      n++;
      if (n > 40)
      begin
        errors++;
        stop_test();
      end
    end
  endtask
  task automatic cycle_req();
    userCycleReq = 1'b1;
    tick(1);
    userCycleReq = 1'b0;
  endtask
  task automatic xfer(input logic dir);
    bus(1'b1, 3'h0, 1'b0, 16'hFFFF);
    bus(1'b1, 3'h2, 1'b0, 16'hFFFE);
    bus(1'b1, 3'h4, 1'b0, {8'h00, 2'b01, x, 4'h1});
    userC1 = dir;
    cycle_req();
    await(1'b0, 1'b1);
    cmp("memAddr", {x, 16'hFFFE}, memAddr);
    cmp("memWrite", 18'(dir), 18'(memWrite));
    await(1'b1, 1'b1);
    cmp("intRequest", 18'h1, 18'(intRequest));
    rv = dir ? lastWrite : userDataOut;
    cmp("data", dir ? 18'h05A3C : 18'h0FEC3, 18'(rv));
    bus(1'b0, 3'h0, 1'b0, 16'h0000);
    cmp("count", 18'h0, 18'(rv));
    bus(1'b0, 3'h2, 1'b0, 16'h0000);
    cmp("pointer", 18'h0, 18'(rv));
    x = x + 2'h1;
    bus(1'b0, 3'h4, 1'b0, 16'h0000);
    cmp("carry", 18'(x), 18'(rv[5:4]));
  endtask
  initial
  begin
    tick(3);
    rst_n = 1'b1;
    tick(1);
    cmp("ready", 18'h1, 18'(userReady));
    userInLoad = 1'b1;
    tick(1);
    userInLoad = 1'b0;
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, rows[i].b, rows[i].d);
      bus(1'b0, rows[i].ra, 1'b0, 16'h0000);
      cmp("row", 18'(rows[i].e), 18'(rv));
    end
    cmp("outbuf", 18'h0BEEF, {2'b00, userDataOut});
    bus(1'b1, 3'h7, 1'b1, 16'h1200);
    bus(1'b1, 3'h6, 1'b1, 16'h0034);
    cmp("outbyte", 18'h01234, {2'b00, userDataOut});
    bus(1'b0, 3'h5, 1'b1, 16'h0000);
    cmp("ctlbyte", 18'h00A80, 18'(rv));
    userAddr0 = 1'b1;
    bus(1'b0, 3'h2, 1'b0, 16'h0000);
    cmp("addr0", 18'h01235, 18'(rv));
    userAddr0 = 1'b0;
    xfer(1'b1);
    delay = 4'h5;
    xfer(1'b0);
    mute = 1'b1;
    bus(1'b1, 3'h0, 1'b0, 16'hFFFF);
    bus(1'b1, 3'h4, 1'b0, {8'h00, 2'b01, x, 4'h1});
    cycle_req();
    await(1'b0, 1'b1);
    tick(1);
    cmp("busy", 18'h0, 18'(userBusy_n));
    tick(TO + 3);
    cmp("timeout", 18'h0, 18'(memReq));
    cmp("idle", 18'h1, 18'(userBusy_n));
    exp = 16'hCAC0 | {10'h000, x, 4'h0};
    bus(1'b0, 3'h4, 1'b0, 16'h0000);
    cmp("nex", 18'(exp), 18'(rv));
    cycle_req();
    tick(6);
    cmp("blocked", 18'h0, 18'(memReq));
    mute = 1'b0;
    bus(1'b1, 3'h5, 1'b1, 16'h0000);
    bus(1'b0, 3'h4, 1'b0, 16'h0000);
    cmp("nexclear", 18'(exp & 16'h3FFF), 18'(rv));
    userAttention = 1'b1;
    tick(2);
    bus(1'b0, 3'h4, 1'b0, 16'h0000);
    cmp("attention", 18'(exp & 16'h3FFF | 16'hA000), 18'(rv));
    userAttention = 1'b0;
    tick(2);
    bus(1'b0, 3'h4, 1'b0, 16'h0000);
    cmp("attnclear", 18'(exp & 16'h3FFF), 18'(rv));
    // Byte cycle primed by software through the cycle bit, pointer increment held off
    userC1 = 1'b1;
    userC0 = 1'b1;
    ptrIncEnable = 1'b0;
    bus(1'b1, 3'h4, 1'b0, 16'h0101);
    await(1'b0, 1'b1);
    cmp("memByte", 18'h1, 18'(memByte));
    await(1'b1, 1'b1);
    bus(1'b0, 3'h2, 1'b0, 16'h0000);
    cmp("ptrhold", 18'h0, 18'(rv));
    rst_n = 1'b0;
    tick(3);
    rst_n = 1'b1;
    tick(1);
    bus(1'b0, 3'h4, 1'b0, 16'h0000);
    cmp("reinit", 18'h00A80, 18'(rv));
    stop_test();
  end
  initial
  begin
    #50000;
    errors++;
    stop_test();
  end
endmodule
bind pdma_regs pdma_regs_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_pdma_regs_monitor (.clock,
  .rst_n, .regAddr, .regWrite, .regRead, .regByte, .regWdata, .regRdata, .regAck, .intRequest,
  .memReq, .userAttention, .userStatus, .userDataOut, .userFunction, .userReady, .userInit);
